// file: sim/ampsc_props.sv
/*
  assertions on the link pins and device state of the two joined ends.
  assumes one ref_clk domain and a synchronous active-low reset_n.
*/
`timescale 1ns/1ns
module ampsc_props #(
  parameter int READY_CYC = 200
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic rst_pin_n,
  input wire logic scl,
  input wire logic sda,
  input wire logic vbat_ok,
  input wire ampsc_pkg::ampsc_state_t state,
  input wire logic i2c_on,
  input wire logic amp_on,
  input wire logic clocks_ok
);
  import ampsc_pkg::*;
  logic [17:0] lo_r;
  logic [17:0] hi_r;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  // pin low run length, saturating so long holds never wrap
  always_ff @(posedge ref_clk) begin
    if (!reset_n || rst_pin_n) lo_r <= '0;
    else if (!(&lo_r)) lo_r <= lo_r + 18'h1;
  end
  // pin high run length, bounds the first control transfer
  always_ff @(posedge ref_clk) begin
    if (!reset_n || !rst_pin_n) hi_r <= '0;
    else if (!(&hi_r)) hi_r <= hi_r + 18'h1;
  end
  por_hw_a: assert property ($rose(reset_n) |-> state == ST_HW && !i2c_on)
    else $error("not in hardware shutdown after reset");
  pin_hold_a: assert property (!rst_pin_n [*6] |-> state == ST_HW && !i2c_on)
    else $error("reset pin low but not in hardware shutdown");
  uvlo_a: assert property (!vbat_ok [*6] |-> state == ST_HW)
    else $error("battery low but not in hardware shutdown");
  hw_exit_a: assert property (state == ST_HW ##1 state != ST_HW |-> state == ST_INIT && rst_pin_n && vbat_ok)
    else $error("bad exit from hardware shutdown");
  init_run_a: assert property ($rose(state == ST_INIT) |-> (state == ST_INIT) [*8] ##[8:30] state == ST_SW)
    else $error("trim load did not end in software shutdown");
  low_time_a: assert property ($rose(rst_pin_n) |-> lo_r >= RST_LOW_CYC)
    else $error("reset pin low time too short");
  ready_wait_a: assert property ($fell(sda) && scl |-> hi_r >= READY_CYC)
    else $error("transfer started before link ready");
  sw_only_a: assert property (state == ST_SW |-> i2c_on && !amp_on)
    else $error("software shutdown outputs wrong");
  act_entry_a: assert property ($rose(state == ST_ACT) |-> $past(state) == ST_SW && $past(clocks_ok) && amp_on)
    else $error("bad entry to active");
  act_exit_a: assert property ($fell(state == ST_ACT) |-> state == ST_SW || state == ST_HW)
    else $error("bad exit from active");
  act_c: cover property ($rose(state == ST_ACT));
  leave_c: cover property ($fell(state == ST_ACT));
  start_c: cover property ($fell(sda) && scl);
endmodule

// file: sim/ampsc_test.sv
/*
  bench joining host and device ends over the link interface.
  assumes shortened ready, quarter and clock-loss counts.
*/
`timescale 1ns/1ns
module ampsc_test;
  import ampsc_pkg::*;
  localparam int READY = 200;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic vbat_ok = 1'b1;
  logic vdd_ok = 1'b1;
  logic spk_fault = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata;
  logic [31:0] s;
  logic [1:0] addr_strap = 2'h0;
  logic [7:0] die_temp_c = 8'h19;
  ampsc_state_t state;
  logic i2c_on, trim_load, pcm_on, amp_on, clocks_ok, therm_trip;
  logic [3:0] spk_rate_sel;
  logic [1:0] frame_delay;
  int num_errors = 0;
  int checks = 0;
  ampsc_link_if link();
  // reference clock
  always #5 ref_clk = ~ref_clk;
  ampsc_host #(.READY_CYC(READY), .Q_CYC(8)) i_ampsc_host (.ref_clk(ref_clk), .reset_n(reset_n), .link(link),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
  ampsc_dev #(.LOSS_CYC(3000)) i_ampsc_dev (.ref_clk(ref_clk), .reset_n(reset_n), .link(link), .vbat_ok(vbat_ok),
    .vdd_ok(vdd_ok), .addr_strap(addr_strap), .die_temp_c(die_temp_c), .spk_fault(spk_fault), .state(state),
    .i2c_on(i2c_on), .trim_load(trim_load), .pcm_on(pcm_on), .amp_on(amp_on), .clocks_ok(clocks_ok),
    .therm_trip(therm_trip), .spk_rate_sel(spk_rate_sel), .frame_delay(frame_delay));
  ampsc_props #(.READY_CYC(READY)) i_ampsc_props (.ref_clk(ref_clk), .reset_n(reset_n), .rst_pin_n(link.rst_pin_n),
    .scl(link.scl), .sda(link.sda), .vbat_ok(vbat_ok), .state(state), .i2c_on(i2c_on), .amp_on(amp_on),
    .clocks_ok(clocks_ok));
  task automatic chk(string n, logic [31:0] sn, logic [31:0] e);
    checks++;
    if (sn !== e) begin
      num_errors++;
      $display("MISMATCH %s expected %0h seen %0h", n, e, sn);
    end
  endtask
  task automatic put(logic [3:0] a, logic [31:0] d);
    @(posedge ref_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge ref_clk);
    wr <= 1'b0;
  endtask
  // status is valid only in the cycle after the read strobe
  task automatic stat();
    @(posedge ref_clk);
    addr <= H_STAT;
    rd <= 1'b1;
    @(posedge ref_clk);
    rd <= 1'b0;
    #1 s = rdata;
  endtask
  task automatic rdy();
    s = 32'h0;
    for (int i = 0; i < 400 && s[1] !== 1'b1; i++) stat();
    chk("ready", s[1], 1'b1);
  endtask
  task automatic xfer(logic [7:0] r, logic [7:0] d, logic nack);
    put(H_XFER, {16'h0, r, d});
    s = 32'h1;
    for (int i = 0; i < 1000 && s[0] !== 1'b0; i++) stat();
    chk("busy", s[0], 1'b0);
    chk("nack", s[3], nack);
  endtask
  task automatic wst(ampsc_state_t e, int n);
    for (int i = 0; i < n && state !== e; i++) begin
      @(posedge ref_clk);
      #1;
    end
    chk("state", state, e);
  endtask
  task automatic t_boot();
    chk("state", state, ST_HW);
    chk("rate", spk_rate_sel, RATE_RST);
    put(H_CTRL, 32'h1);
    wst(ST_SW, 1200);
    chk("link", i2c_on, 1'b1);
    chk("delay", frame_delay, 2'h1);
    rdy();
    $display("boot done");
  endtask
  // 192k with ratio 128 sits exactly on the bit clock ceiling
  task automatic t_play();
    xfer(REG_RATIO_LO, 8'h80, 1'b0);
    xfer(REG_RATE, 8'h0C, 1'b0);
    put(H_CLK, 32'h0004_0080);
    put(H_CTRL, 32'h3);
    xfer(REG_CTRL, 8'h05, 1'b0);
    wst(ST_ACT, 4000);
    chk("pcm", pcm_on, 1'b1);
    chk("clocks", clocks_ok, 1'b1);
    chk("speaker rate", spk_rate_sel, 4'hC);
    @(posedge ref_clk) spk_fault <= 1'b1;
    wst(ST_SW, 20);
    @(posedge ref_clk) spk_fault <= 1'b0;
    wst(ST_ACT, 4000);
    @(posedge ref_clk) die_temp_c <= 8'h95;
    repeat (3) @(posedge ref_clk);
    #1 chk("trip", therm_trip, 1'b0);
    @(posedge ref_clk) die_temp_c <= 8'h96;
    wst(ST_SW, 20);
    chk("trip", therm_trip, 1'b1);
    @(posedge ref_clk) die_temp_c <= 8'h19;
    wst(ST_ACT, 4000);
    $display("play done");
  endtask
  task automatic t_stop();
    xfer(REG_CTRL, 8'h02, 1'b0);
    wst(ST_SW, 20);
    chk("rate", spk_rate_sel, RATE_RST);
    chk("pcm", pcm_on, 1'b0);
    xfer(REG_RATIO_LO, 8'h80, 1'b0);
    xfer(REG_RATE, 8'h0D, 1'b0);
    xfer(REG_CTRL, 8'h05, 1'b0);
    repeat (3000) @(posedge ref_clk);
    #1 chk("state", state, ST_SW);
    chk("clocks", clocks_ok, 1'b0);
    xfer(REG_RATE, 8'h08, 1'b0);
    xfer(REG_CTRL, 8'h05, 1'b0);
    wst(ST_ACT, 4000);
    xfer(REG_CTRL, 8'h04, 1'b0);
    wst(ST_SW, 20);
    chk("amp", amp_on, 1'b0);
    for (int m = 0; m < 4; m++) begin
      xfer(REG_FMT, {4'h0, m[1:0], FMT_TDM}, 1'b0);
      chk("delay", frame_delay, (m > 2) ? DELAY_MAX : m[1:0]);
    end
    xfer(REG_FMT, {6'h0, FMT_LJ}, 1'b0);
    chk("delay", frame_delay, 2'h0);
    $display("stop done");
  endtask
  task automatic t_power();
    @(posedge ref_clk) vbat_ok <= 1'b0;
    wst(ST_HW, 10);
    chk("link", i2c_on, 1'b0);
    repeat (5) @(posedge ref_clk);
    vbat_ok <= 1'b1;
    vdd_ok <= 1'b0;
    wst(ST_INIT, 10);
    @(posedge ref_clk);
    #1 chk("trim", trim_load, 1'b1);
    repeat (20) @(posedge ref_clk);
    #1 chk("state", state, ST_INIT);
    @(posedge ref_clk) vdd_ok <= 1'b1;
    wst(ST_SW, 60);
    chk("trim", trim_load, 1'b0);
    chk("delay", frame_delay, 2'h1);
    @(posedge ref_clk) addr_strap <= 2'h2;
    put(H_CTRL, 32'h8);
    wst(ST_HW, 10);
    put(H_CTRL, 32'h9);
    wst(ST_SW, 1200);
    rdy();
    xfer(REG_THERM, 8'h64, 1'b0);
    put(H_CTRL, 32'h5);
    xfer(REG_THERM, 8'h64, 1'b1);
    $display("power done");
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (20) @(posedge ref_clk);
    reset_n <= 1'b1;
    @(posedge ref_clk);
    #1;
    t_boot();
    t_play();
    t_stop();
    t_power();
    end_of_test();
  end
  // watchdog well past the expected run
  initial begin
    #900000;
    num_errors++;
    end_of_test();
  end
endmodule

// file: src/ampsc_dev.sv
/*
  device end: power state control, write-only control link target and pcm
  clock checker with the control registers it steers.
  assumes reset pin, link and pcm pins, supply flags and strap are asynchronous;
  die temperature and speaker fault come from logic on ref_clk.
*/
// Overview of operation
// - power-up or hardware reset starts in hardware shutdown
// - hardware shutdown resets registers, disables control link
// - leaving hardware shutdown loads trim, then software shutdown
// - reset pin low forces hardware shutdown
// - battery undervoltage forces hardware shutdown
// - exit needs battery ok, pin high, core supply; here core supply only gates the step from trim load to software shutdown
// - host holds reset low for minimum time
// - control link ready within limit after release
// - software shutdown: only control link, registers kept; pcm interface stays on here when receive path is enabled
// - enable plus valid clocks enters active
// - clearing enable returns to software shutdown
// - software reset bit resets into software shutdown
// - host writes only safe settings while active
// - other active entries or exits only by faults
// - pcm rates 8kHz to 192kHz, three formats
// - receive path disabled powers pcm interface down
// - host supplies bit clock and frame clock
// - rate setting matches frame clock, sets speaker rate
// - ratio 32..512, bit clock at most 24.576MHz
// - first bit delay 0..2 cycles by mode
// - address strap picks one of four addresses
// - trip code 0x64 means 150 C
`timescale 1ns/1ns
module ampsc_dev #(
  parameter int LOSS_CYC = ampsc_pkg::CLK_LOSS_CYC,
  parameter int OTP_CYC = ampsc_pkg::OTP_LOAD_CYC,
  parameter logic [6:0] ADDR_BASE = ampsc_pkg::I2C_ADDR_BASE
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  ampsc_link_if.dev link,
  input wire logic vbat_ok,
  input wire logic vdd_ok,
  input wire logic [1:0] addr_strap,
  input wire logic [7:0] die_temp_c,
  input wire logic spk_fault,
  output ampsc_pkg::ampsc_state_t state,
  output logic i2c_on,
  output logic trim_load,
  output logic pcm_on,
  output logic amp_on,
  output logic clocks_ok,
  output logic therm_trip,
  output logic [3:0] spk_rate_sel,
  output logic [1:0] frame_delay
);
  import ampsc_pkg::*;

  logic [SY_W-1:0] raw, syn, rise, fall;
  ampsc_state_t state_r, state_nxt;
  logic hw_hold, fault, sw_rst, wr_stb, otp_done, cfg_ok, frame_edge;
  logic i2c_on_r, trim_r, pcm_on_r, amp_on_r, clk_ok_r, trip_r;
  logic [7:0] otp_cnt_r;
  logic [1:0] strap_r;
  logic [7:0] sh_r, ptr_r;
  logic [3:0] bit_r;
  logic [1:0] byte_r;
  logic busy_r, sel_r, oe_n_r;
  logic en_r, rx_en_r;
  logic [3:0] rate_r, fmt_r;
  logic [9:0] ratio_r, bcnt_r;
  logic [7:0] trip_lvl_r;
  logic [15:0] tmo_r;
  logic seen_r;
  logic [1:0] delay_r;
  logic [27:0] bclk_hz;

  // every pin passes two flops before use
  assign raw = {addr_strap, link.rst_pin_n, vbat_ok, vdd_ok, link.scl, link.sda, link.bclk, link.lrclk};
  ampsc_sync #(.W(SY_W), .INIT(SY_INIT)) u_sync (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .d(raw),
    .q(syn),
    .rise(rise),
    .fall(fall)
  );

  assign hw_hold = !syn[SY_RST] || !syn[SY_VBAT];
  assign otp_done = (otp_cnt_r == 8'(OTP_CYC - 1));
  // clock loss counts as a fault too, it drops playback
  assign fault = trip_r || spk_fault || !clk_ok_r;
  assign wr_stb = busy_r && fall[SY_SCL] && bit_r == 4'h8 && byte_r == 2'h2 && sel_r;
  assign sw_rst = wr_stb && ptr_r == REG_CTRL && sh_r[CTRL_RST_BIT];

  // next state; hardware hold wins over everything
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_HW: if (!hw_hold) state_nxt = ST_INIT;
      ST_INIT: if (otp_done && syn[SY_VDD]) state_nxt = ST_SW;
      ST_SW: if (en_r && clk_ok_r && !trip_r && !spk_fault) state_nxt = ST_ACT;
      ST_ACT: if (!en_r || fault) state_nxt = ST_SW;
      default: state_nxt = ST_HW;
    endcase
    if (sw_rst) state_nxt = ST_SW;
    if (hw_hold) state_nxt = ST_HW;
  end

  // state and the block enables that follow it
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      state_r <= ST_HW;
      i2c_on_r <= 1'b0;
      amp_on_r <= 1'b0;
      pcm_on_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      i2c_on_r <= (state_nxt == ST_SW) || (state_nxt == ST_ACT);
      amp_on_r <= (state_nxt == ST_ACT);
      pcm_on_r <= rx_en_r && !sw_rst && ((state_nxt == ST_SW) || (state_nxt == ST_ACT));
    end
  end

  // trim load runs for a fixed time on the way out of hardware shutdown
  always_ff @(posedge ref_clk) begin
    if (!reset_n || state_r != ST_INIT) begin
      otp_cnt_r <= 8'h00;
      trim_r <= 1'b0;
    end else begin
      trim_r <= !otp_done;
      if (!otp_done) otp_cnt_r <= otp_cnt_r + 8'h01;
    end
  end

  // strap caught while held in hardware shutdown, stable afterwards
  always_ff @(posedge ref_clk) begin
    if (!reset_n) strap_r <= 2'h0;
    else if (state_r == ST_HW) strap_r <= syn[SY_STRAP +: 2];
  end

  // control link target: address, pointer, then data bytes with auto-increment
  always_ff @(posedge ref_clk) begin
    if (!reset_n || !i2c_on_r) begin
      busy_r <= 1'b0;
      bit_r <= 4'h0;
      byte_r <= 2'h0;
      sel_r <= 1'b0;
      oe_n_r <= 1'b1;
      sh_r <= 8'h00;
      ptr_r <= 8'h00;
    end else if (syn[SY_SCL] && fall[SY_SDA]) begin
      busy_r <= 1'b1;
      bit_r <= 4'h0;
      byte_r <= 2'h0;
      sel_r <= 1'b0;
      oe_n_r <= 1'b1;
    end else if (syn[SY_SCL] && rise[SY_SDA]) begin
      busy_r <= 1'b0;
      oe_n_r <= 1'b1;
    end else if (busy_r) begin
      if (rise[SY_SCL] && bit_r < 4'h8) begin
        sh_r <= {sh_r[6:0], syn[SY_SDA]};
        bit_r <= bit_r + 4'h1;
      end
      if (fall[SY_SCL] && bit_r == 4'h8) begin
        bit_r <= 4'h9;
        if (byte_r == 2'h0) begin
          sel_r <= (sh_r == {ADDR_BASE[6:2], strap_r, 1'b0});
          oe_n_r <= !(sh_r == {ADDR_BASE[6:2], strap_r, 1'b0});
        end else begin
          oe_n_r <= !sel_r;
        end
        if (byte_r == 2'h1 && sel_r) ptr_r <= sh_r;
        if (wr_stb) ptr_r <= ptr_r + 8'h01;
      end
      if (fall[SY_SCL] && bit_r == 4'h9) begin
        bit_r <= 4'h0;
        oe_n_r <= 1'b1;
        if (byte_r != 2'h2) byte_r <= byte_r + 2'h1;
      end
    end
  end

  // registers: any state with a working link may write them
  always_ff @(posedge ref_clk) begin
    if (!reset_n || state_r == ST_HW || sw_rst) begin
      en_r <= 1'b0;
      rx_en_r <= 1'b0;
      rate_r <= RATE_RST;
      ratio_r <= RATIO_RST;
      fmt_r <= FMT_RST;
      trip_lvl_r <= TRIP_RST;
    end else if (wr_stb) begin
      case (ptr_r)
        REG_CTRL: begin
          en_r <= sh_r[CTRL_EN_BIT];
          rx_en_r <= sh_r[CTRL_RX_BIT];
        end
        REG_RATE: rate_r <= sh_r[3:0];
        REG_RATIO_LO: ratio_r[7:0] <= sh_r;
        REG_RATIO_HI: ratio_r[9:8] <= sh_r[1:0];
        REG_FMT: fmt_r <= sh_r[3:0];
        REG_THERM: trip_lvl_r <= sh_r;
        default: ;
      endcase
    end
  end

  // configuration fit: rate supported, ratio in range, bit clock not too fast
  assign bclk_hz = 28'(ampsc_rate_hz(rate_r)) * 28'(ratio_r);
  assign cfg_ok = (ampsc_rate_hz(rate_r) != 18'h00000)
    && ratio_r >= RATIO_MIN && ratio_r <= RATIO_MAX && bclk_hz <= BCLK_MAX_HZ;
  // tdm frames start on the rising frame clock, two-channel ones on falling
  assign frame_edge = (fmt_r[1:0] == FMT_TDM) ? rise[SY_LR] : fall[SY_LR];

  // clock checker: bit clocks per frame must equal the ratio; held off when pcm is down
  always_ff @(posedge ref_clk) begin
    if (!reset_n || !pcm_on_r) begin
      bcnt_r <= 10'h000;
      tmo_r <= 16'h0000;
      seen_r <= 1'b0;
      clk_ok_r <= 1'b0;
    end else if (frame_edge) begin
      bcnt_r <= 10'h000;
      tmo_r <= 16'h0000;
      seen_r <= 1'b1;
      clk_ok_r <= seen_r && cfg_ok && (bcnt_r == ratio_r);
    end else begin
      if (rise[SY_BCLK] && bcnt_r != 10'h3FF) bcnt_r <= bcnt_r + 10'h001;
      // a stopped frame clock must not leave a stale ok behind
      if (tmo_r == 16'(LOSS_CYC - 1)) clk_ok_r <= 1'b0;
      else tmo_r <= tmo_r + 16'h0001;
    end
  end

  // thermal trip compared without subtraction to avoid wrap on small codes
  always_ff @(posedge ref_clk) begin
    if (!reset_n) trip_r <= 1'b0;
    else trip_r <= ({1'b0, die_temp_c} + TRIP_REF_CODE) >= ({1'b0, trip_lvl_r} + TRIP_REF_C);
  end

  // first data bit delay in bit clocks
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      delay_r <= 2'h1;
    end else begin
      case (fmt_r[1:0])
        FMT_I2S: delay_r <= 2'h1;
        FMT_LJ: delay_r <= 2'h0;
        default: delay_r <= (fmt_r[3:2] > DELAY_MAX) ? DELAY_MAX : fmt_r[3:2];
      endcase
    end
  end

  assign state = state_r;
  assign i2c_on = i2c_on_r;
  assign trim_load = trim_r;
  assign pcm_on = pcm_on_r;
  assign amp_on = amp_on_r;
  assign clocks_ok = clk_ok_r;
  assign therm_trip = trip_r;
  assign spk_rate_sel = rate_r;
  assign frame_delay = delay_r;
  assign link.sda_dev_o = 1'b0;
  assign link.sda_dev_oe_n = oe_n_r;
endmodule

// file: src/ampsc_host.sv
/*
  host end: drives the reset pin with its minimum low time, waits for the
  control link, sends register writes and makes the pcm clocks.
  assumes a software port with one-cycle strobes and read data a cycle later.
*/
`timescale 1ns/1ns
module ampsc_host #(
  parameter int READY_CYC = ampsc_pkg::I2C_READY_CYC,
  parameter int Q_CYC = ampsc_pkg::I2C_Q_CYC
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  ampsc_link_if.host link,
  input wire logic [3:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata
);
  import ampsc_pkg::*;

  logic sda_q;
  logic rel_req_r, clk_run_r, rst_pin_r, ready_r, nack_r, scl_r, oe_n_r, bclk_r, lr_r;
  logic [1:0] tgt_r, ph_r;
  logic [9:0] hratio_r, bc_r, low_cnt_r;
  logic [7:0] half_r, div_r, tick_r;
  logic [31:0] rdy_cnt_r, rdata_r;
  logic [4:0] bit_r;
  logic [FRAME_BITS-1:0] frm_r;
  ampsc_mst_t st_r;
  logic low_met, go, tick_end;

  ampsc_sync #(.W(1), .INIT(1'b1)) u_sync (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .d(link.sda),
    .q(sda_q),
    .rise(),
    .fall()
  );

  assign low_met = (low_cnt_r == 10'(RST_LOW_CYC - 1));
  // a transfer is refused until the device link is ready and the master is idle
  assign go = wr && addr == H_XFER && st_r == HI_IDLE && ready_r;
  assign tick_end = (tick_r == 8'(Q_CYC - 1));

  // software port
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      rel_req_r <= 1'b0;
      clk_run_r <= 1'b0;
      tgt_r <= 2'h0;
      hratio_r <= RATIO_RST;
      half_r <= 8'(BCLK_HALF_CYC);
      rdata_r <= 32'h00000000;
    end else begin
      if (wr && addr == H_CTRL) begin
        rel_req_r <= wdata[0];
        clk_run_r <= wdata[1];
        tgt_r <= wdata[3:2];
      end
      if (wr && addr == H_CLK) begin
        hratio_r <= wdata[9:0];
        half_r <= wdata[23:16];
      end
      // read data stands only in the cycle after the strobe
      if (!rd) rdata_r <= 32'h00000000;
      else begin
        case (addr)
          H_CTRL: rdata_r <= {28'h0000000, tgt_r, clk_run_r, rel_req_r};
          H_STAT: rdata_r <= {28'h0000000, nack_r, low_met, ready_r, st_r != HI_IDLE};
          H_CLK: rdata_r <= {8'h00, half_r, 6'h00, hratio_r};
          default: rdata_r <= 32'h00000000;
        endcase
      end
    end
  end

  // reset pin: low for at least the minimum, then wait for the link to come up
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      rst_pin_r <= 1'b0;
      low_cnt_r <= 10'h000;
      rdy_cnt_r <= 32'h00000000;
      ready_r <= 1'b0;
    end else if (!rst_pin_r) begin
      ready_r <= 1'b0;
      rdy_cnt_r <= 32'h00000000;
      if (!low_met) low_cnt_r <= low_cnt_r + 10'h001;
      else if (rel_req_r) rst_pin_r <= 1'b1;
    end else begin
      low_cnt_r <= 10'h000;
      if (!rel_req_r) rst_pin_r <= 1'b0;
      else if (!ready_r) begin
        if (rdy_cnt_r == 32'(READY_CYC - 1)) ready_r <= 1'b1;
        rdy_cnt_r <= rdy_cnt_r + 32'h00000001;
      end
    end
  end

  // write master: start, three bytes each with an ack slot, stop
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      st_r <= HI_IDLE;
      scl_r <= 1'b1;
      oe_n_r <= 1'b1;
      ph_r <= 2'h0;
      tick_r <= 8'h00;
      bit_r <= 5'h00;
      frm_r <= '1;
      nack_r <= 1'b0;
    end else if (st_r == HI_IDLE) begin
      if (go) begin
        st_r <= HI_START;
        frm_r <= {I2C_ADDR_BASE[6:2], tgt_r, 1'b0, 1'b1, wdata[15:8], 1'b1, wdata[7:0], 1'b1};
        nack_r <= 1'b0;
        tick_r <= 8'h00;
        ph_r <= 2'h0;
        bit_r <= 5'h00;
      end
    end else if (!tick_end) begin
      tick_r <= tick_r + 8'h01;
    end else begin
      tick_r <= 8'h00;
      ph_r <= ph_r + 2'h1;
      case (st_r)
        HI_START: begin
          if (ph_r == 2'h0) oe_n_r <= 1'b0;
          if (ph_r == 2'h1) begin
            scl_r <= 1'b0;
            ph_r <= 2'h0;
            st_r <= HI_BITS;
          end
        end
        HI_BITS: begin
          case (ph_r)
            2'h0: oe_n_r <= frm_r[FRAME_BITS-1];
            2'h1: scl_r <= 1'b1;
            2'h2: if ((bit_r == ACK_B0 || bit_r == ACK_B1 || bit_r == ACK_B2) && sda_q) nack_r <= 1'b1;
            default: begin
              scl_r <= 1'b0;
              frm_r <= {frm_r[FRAME_BITS-2:0], 1'b1};
              bit_r <= bit_r + 5'h01;
              if (bit_r == 5'(FRAME_BITS - 1)) st_r <= HI_STOP;
            end
          endcase
        end
        HI_STOP: begin
          case (ph_r)
            2'h0: oe_n_r <= 1'b0;
            2'h1: scl_r <= 1'b1;
            2'h2: oe_n_r <= 1'b1;
            default: st_r <= HI_IDLE;
          endcase
        end
        default: st_r <= HI_IDLE;
      endcase
    end
  end

  // pcm clocks from a divider; frame clock moves on bit clock falling edges
  always_ff @(posedge ref_clk) begin
    if (!reset_n || !clk_run_r) begin
      div_r <= 8'h00;
      bclk_r <= 1'b0;
      lr_r <= 1'b1;
      bc_r <= 10'h000;
    end else if (div_r + 8'h01 >= half_r) begin
      div_r <= 8'h00;
      bclk_r <= !bclk_r;
      if (bclk_r) begin
        if (bc_r >= hratio_r - 10'h001) begin
          bc_r <= 10'h000;
          lr_r <= 1'b0;
        end else begin
          bc_r <= bc_r + 10'h001;
          if (bc_r + 10'h001 == (hratio_r >> 1)) lr_r <= 1'b1;
        end
      end
    end else begin
      div_r <= div_r + 8'h01;
    end
  end

  assign rdata = rdata_r;
  assign link.rst_pin_n = rst_pin_r;
  assign link.scl = scl_r;
  assign link.sda_host_o = 1'b0;
  assign link.sda_host_oe_n = oe_n_r;
  assign link.bclk = bclk_r;
  assign link.lrclk = lr_r;
endmodule

// file: src/ampsc_link_if.sv
/*
  link between host and device: reset pin, control clock and open-drain data,
  pcm bit and frame clocks.
  assumes a pull-up on the data line, modelled by the wired-and below.
*/
`timescale 1ns/1ns
interface ampsc_link_if;
  logic rst_pin_n;
  logic scl;
  logic sda_host_o;
  logic sda_host_oe_n;
  logic sda_dev_o;
  logic sda_dev_oe_n;
  logic sda;
  logic bclk;
  logic lrclk;

  // pulled high unless an end drives low
  assign sda = (sda_host_oe_n | sda_host_o) & (sda_dev_oe_n | sda_dev_o);

  modport host (output rst_pin_n, scl, sda_host_o, sda_host_oe_n, bclk, lrclk, input sda);
  modport dev (input rst_pin_n, scl, sda, bclk, lrclk, output sda_dev_o, sda_dev_oe_n);
endinterface

// file: src/ampsc_pkg.sv
/*
  shared constants for the amplifier state control blocks: states, control
  register map of the device, host command map, link timing and pcm limits.
  assumes a 100 MHz ref_clk on both ends.
*/
package ampsc_pkg;
  // clock and link timing
  localparam int CLK_PERIOD_NS = 10;
  localparam real RST_LOW_MIN_US = 7.5;
  localparam int RST_LOW_CYC = int'($ceil(RST_LOW_MIN_US * 1000.0 / CLK_PERIOD_NS));
  localparam real I2C_READY_MAX_MS = 1.5;
  localparam int I2C_READY_CYC = int'($floor(I2C_READY_MAX_MS * 1000000.0 / CLK_PERIOD_NS));
  localparam int I2C_Q_CYC = 63;
  localparam int OTP_LOAD_CYC = 16;
  localparam int CLK_LOSS_CYC = 13000;
  localparam int BCLK_HALF_CYC = 4;
  // link address base, value arbitrary
  localparam logic [6:0] I2C_ADDR_BASE = 7'h30;
  localparam int FRAME_BITS = 27;
  localparam logic [4:0] ACK_B0 = 5'h08;
  localparam logic [4:0] ACK_B1 = 5'h11;
  localparam logic [4:0] ACK_B2 = 5'h1A;

  // device control registers and reset values
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_RATE = 8'h01;
  localparam logic [7:0] REG_RATIO_LO = 8'h02;
  localparam logic [7:0] REG_RATIO_HI = 8'h03;
  localparam logic [7:0] REG_FMT = 8'h04;
  localparam logic [7:0] REG_THERM = 8'h05;
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_RST_BIT = 1;
  localparam int CTRL_RX_BIT = 2;
  localparam logic [3:0] RATE_RST = 4'h8;
  localparam logic [9:0] RATIO_RST = 10'h040;
  localparam logic [3:0] FMT_RST = 4'h0;
  localparam logic [7:0] TRIP_RST = 8'h64;
  localparam logic [1:0] FMT_I2S = 2'h0;
  localparam logic [1:0] FMT_LJ = 2'h1;
  localparam logic [1:0] FMT_TDM = 2'h2;
  localparam logic [1:0] DELAY_MAX = 2'h2;

  // pcm limits
  localparam logic [9:0] RATIO_MIN = 10'h020;
  localparam logic [9:0] RATIO_MAX = 10'h200;
  localparam logic [27:0] BCLK_MAX_HZ = 28'h1770000;
  // thermal trip: code 0x64 means 150 C
  localparam logic [8:0] TRIP_REF_CODE = 9'h064;
  localparam logic [8:0] TRIP_REF_C = 9'h096;

  // host command map
  localparam logic [3:0] H_CTRL = 4'h0;
  localparam logic [3:0] H_XFER = 4'h4;
  localparam logic [3:0] H_STAT = 4'h8;
  localparam logic [3:0] H_CLK = 4'hC;

  // positions in the device input synchroniser
  localparam int SY_LR = 0;
  localparam int SY_BCLK = 1;
  localparam int SY_SDA = 2;
  localparam int SY_SCL = 3;
  localparam int SY_VDD = 4;
  localparam int SY_VBAT = 5;
  localparam int SY_RST = 6;
  localparam int SY_STRAP = 7;
  localparam int SY_W = 9;
  localparam logic [8:0] SY_INIT = 9'h00D;

  typedef enum logic [3:0] {
    ST_HW = 4'b0001,
    ST_INIT = 4'b0010,
    ST_SW = 4'b0100,
    ST_ACT = 4'b1000
  } ampsc_state_t;

  typedef enum logic [3:0] {
    HI_IDLE = 4'b0001,
    HI_START = 4'b0010,
    HI_BITS = 4'b0100,
    HI_STOP = 4'b1000
  } ampsc_mst_t;

  // supported sample rates in Hz; zero marks an unsupported code
  function automatic logic [17:0] ampsc_rate_hz(input logic [3:0] sel);
    case (sel)
      4'h0: ampsc_rate_hz = 18'h01F40;
      4'h1: ampsc_rate_hz = 18'h02B11;
      4'h2: ampsc_rate_hz = 18'h02EE0;
      4'h3: ampsc_rate_hz = 18'h03E80;
      4'h4: ampsc_rate_hz = 18'h05622;
      4'h5: ampsc_rate_hz = 18'h05DC0;
      4'h6: ampsc_rate_hz = 18'h07D00;
      4'h7: ampsc_rate_hz = 18'h0AC44;
      4'h8: ampsc_rate_hz = 18'h0BB80;
      4'h9: ampsc_rate_hz = 18'h15888;
      4'hA: ampsc_rate_hz = 18'h17700;
      4'hB: ampsc_rate_hz = 18'h2B110;
      4'hC: ampsc_rate_hz = 18'h2EE00;
      default: ampsc_rate_hz = 18'h00000;
    endcase
  endfunction
endpackage

// file: src/ampsc_sync.sv
/*
  two-flop synchroniser with edge pulses taken after the second flop.
  assumes inputs asynchronous to ref_clk; edges need a third stage.
*/
`timescale 1ns/1ns
module ampsc_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q,
  output logic [W-1:0] rise,
  output logic [W-1:0] fall
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;

  // first stage feeds only the second
  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
        s1_r[i] <= INIT[i];
        s2_r[i] <= INIT[i];
        s3_r[i] <= INIT[i];
      end else begin
        s1_r[i] <= d[i];
        s2_r[i] <= s1_r[i];
        s3_r[i] <= s2_r[i];
      end
    end
    assign rise[i] = s2_r[i] & ~s3_r[i];
    assign fall[i] = ~s2_r[i] & s3_r[i];
  end

  assign q = s2_r;
endmodule
